/* File: rtl/psc_pkg.sv */
package psc_pkg;
   typedef enum logic [5:0] {
      PSC_RESET = 6'b00_0001,
      PSC_RUN = 6'b00_0010,
      PSC_EXC = 6'b00_0100,
      PSC_SLEEP = 6'b00_1000,
      PSC_SWSTBY = 6'b01_0000,
      PSC_HWSTBY = 6'b10_0000
   } psc_state_t;
   typedef enum logic [1:0] {
      PSC_EXC_RESET = 2'h0,
      PSC_EXC_IRQ = 2'h1,
      PSC_EXC_TRAP = 2'h2
   } psc_exc_t;
   localparam logic [1:0] PSC_MODE_BAD = 2'h0;
   localparam logic [1:0] PSC_MODE_1 = 2'h1;
   localparam logic [1:0] PSC_MODE_2 = 2'h2;
   localparam logic [1:0] PSC_MODE_3 = 2'h3;
   localparam logic [1:0] PSC_ST_2 = 2'h2;
   localparam logic [1:0] PSC_ST_3 = 2'h3;
   localparam logic [7:0] PSC_RAM_OFF_DATA = 8'hFF;
   localparam int PSC_AREAS = 8;
   localparam logic [2:0] PSC_SEQ_RESET_LEN = 3'h2;
   localparam logic [2:0] PSC_SEQ_PUSH_LEN = 3'h4;
endpackage

/* File: rtl/psc_bus_timer.sv */
`timescale 1ns/1ps
module psc_bus_timer
   import psc_pkg::*;
#(
   parameter int AREAS = PSC_AREAS
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Access request
   input wire logic i_start,
   input wire logic i_onchip_mem,
   input wire logic i_periph,
   input wire logic [2:0] i_area,
   input wire logic [AREAS-1:0] i_area_three,
   input wire logic [AREAS-1:0] i_area_wide,
   input wire logic i_periph_wide,
   // Cycle result
   output logic o_busy,
   output logic o_done,
   output logic o_wide
);
   logic [1:0] len;
   logic [1:0] cnt_reg, cnt_next;
   logic busy_reg, busy_next;
   logic done_reg, done_next;
   logic wide_reg, wide_next;
   always_comb
   begin
      // Memory two states, peripherals three, external per area
      if (i_onchip_mem)
         len = PSC_ST_2;
      else if (i_periph)
         len = PSC_ST_3;
      else
         len = i_area_three[i_area] ? PSC_ST_3 : PSC_ST_2;
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      wide_next = wide_reg;
      if (busy_reg)
      begin
         cnt_next = cnt_reg - 2'h1;
         if (cnt_reg == 2'h1)
         begin
            busy_next = 1'b0;
            done_next = 1'b1;
         end
      end
      else if (i_start)
      begin
         busy_next = 1'b1;
         cnt_next = len;
         wide_next = i_onchip_mem | (i_periph ? i_periph_wide : i_area_wide[i_area]);
      end
   end
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         cnt_reg <= 2'h0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         wide_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         wide_reg <= wide_next;
      end
   end
   assign o_busy = busy_reg;
   assign o_done = done_reg;
   assign o_wide = wide_reg;
   mem_len_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !busy_reg && i_start && i_onchip_mem |=> busy_reg [*2] ##1 done_reg)
      else $error("on-chip access not two states");
   per_len_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !busy_reg && i_start && !i_onchip_mem && i_periph |=> busy_reg [*3] ##1 done_reg)
      else $error("peripheral access not three states");
endmodule

/* File: rtl/psc_ram_gate.sv */
`timescale 1ns/1ps
module psc_ram_gate
   import psc_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Access
   input wire logic [1:0] i_mode,
   input wire logic i_ram_enable,
   input wire logic i_ram_range,
   input wire logic i_write,
   input wire logic [7:0] i_ram_rdata,
   // Decode
   output logic o_to_external,
   output logic o_ram_write,
   output logic [7:0] o_rdata
);
   logic ext_next, ext_reg, wr_next, wr_reg;
   logic [7:0] rd_next, rd_reg;
   always_comb
   begin
      ext_next = 1'b0;
      wr_next = i_ram_range & i_write;
      rd_next = i_ram_rdata;
      if (i_ram_range && !i_ram_enable)
      begin
         if (i_mode == PSC_MODE_1)
         begin
            ext_next = 1'b1;
            wr_next = 1'b0;
         end
         else
         begin
            wr_next = 1'b0;
            rd_next = PSC_RAM_OFF_DATA;
         end
      end
   end
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ext_reg <= 1'b0;
         wr_reg <= 1'b0;
         rd_reg <= 8'h00;
      end
      else
      begin
         ext_reg <= ext_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end
   assign o_to_external = ext_reg;
   assign o_ram_write = wr_reg;
   assign o_rdata = rd_reg;
   ram_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
      i_ram_range && !i_ram_enable && i_mode != PSC_MODE_1 |=> o_rdata == PSC_RAM_OFF_DATA && !o_ram_write)
      else $error("disabled RAM not blocked");
endmodule

/* File: rtl/psc_top.sv */
`timescale 1ns/1ps
module psc_top
   import psc_pkg::*;
#(
   parameter int AREAS = PSC_AREAS
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Reset sources and standby pin
   input wire logic i_reset_input_low,
   input wire logic i_watchdog_overflow,
   input wire logic i_hw_standby_pin_low,
   // Mode pins
   input wire logic i_mode_pin_high,
   input wire logic i_mode_pin_low,
   // Control bits of the system control register
   input wire logic i_standby_select_bit,
   input wire logic i_user_flag_enable,
   input wire logic i_onchip_ram_enable,
   // Instruction stream
   input wire logic i_instr_end,
   input wire logic i_instr_flags_op,
   input wire logic i_trap_instruction,
   input wire logic i_sleep_instr,
   input wire logic i_wake,
   // Interrupt controller
   input wire logic i_irq_pending,
   input wire logic i_irq_nmi,
   // Bus controller
   input wire logic i_bus_start,
   input wire logic i_bus_onchip_mem,
   input wire logic i_bus_periph,
   input wire logic i_bus_periph_wide,
   input wire logic [2:0] i_bus_area,
   input wire logic [AREAS-1:0] i_area_three,
   input wire logic [AREAS-1:0] i_area_wide,
   input wire logic i_bus_release_req,
   // RAM access
   input wire logic i_ram_range,
   input wire logic i_ram_write,
   input wire logic [7:0] i_ram_rdata,
   // Processing state
   output psc_state_t o_state,
   output logic o_bus_released,
   output logic o_exc_active,
   output psc_exc_t o_exc_kind,
   output logic o_push_ctx,
   output logic o_vector_fetch,
   output logic o_irq_accept,
   // Condition flags
   output logic o_mask_flag,
   output logic o_second_mask_flag,
   // Clock and module control
   output logic o_clock_halt,
   output logic o_modules_reset,
   output logic o_cpu_halt,
   // Mode decode
   output logic [1:0] o_mode,
   output logic o_wide_space,
   output logic o_initial_bus_8bit,
   // Bus timing and RAM gate
   output logic o_bus_busy,
   output logic o_bus_done,
   output logic o_bus_wide,
   output logic o_ram_to_external,
   output logic o_ram_write,
   output logic [7:0] o_ram_rdata
);
   psc_state_t state_reg, state_next;
   psc_exc_t kind_reg, kind_next;
   logic [2:0] seq_reg, seq_next;
   logic mask_reg, mask_next;
   logic umask_reg, umask_next;
   logic noirq_reg, noirq_next;
   logic push_reg, push_next;
   logic vec_reg, vec_next;
   logic acc_reg, acc_next;
   logic rel_reg, rel_next;
   logic [1:0] mode_reg, mode_next;
   logic exc_reg, exc_next;
   logic halt_reg, halt_next;
   logic cpuh_reg, cpuh_next;
   logic wsp_reg, wsp_next;
   logic b8_reg, b8_next;
   logic in_reset;
   logic irq_ok;
   logic seq_last;

   // Reset pin and watchdog share one path
   assign in_reset = !i_reset_input_low || i_watchdog_overflow;
   // Detection point is instruction end or exception end, never after flag ops
   assign seq_last = (state_reg == PSC_EXC) && (seq_reg == 3'h1);
   assign irq_ok = i_irq_pending && (i_irq_nmi || !mask_reg) && !noirq_reg
      && ((i_instr_end && !i_instr_flags_op && state_reg == PSC_RUN) || seq_last);

   always_comb
   begin
      state_next = state_reg;
      kind_next = kind_reg;
      seq_next = seq_reg;
      mask_next = mask_reg;
      umask_next = umask_reg;
      noirq_next = noirq_reg;
      push_next = 1'b0;
      vec_next = 1'b0;
      acc_next = 1'b0;
      rel_next = rel_reg;
      // Mode pins sampled every cycle in reset; outside keeps them steady
      mode_next = mode_reg;
      if (in_reset)
      begin
         state_next = PSC_RESET;
         mask_next = 1'b1;
         noirq_next = 1'b1;
         rel_next = 1'b0;
         mode_next = {i_mode_pin_high, i_mode_pin_low};
      end
      else if (!i_hw_standby_pin_low)
      begin
         state_next = PSC_HWSTBY;
         rel_next = 1'b0;
      end
      else
      begin
         case (state_reg)
            PSC_RESET:
            begin
               // Reset sequence on the synchronous rising edge
               state_next = PSC_EXC;
               kind_next = PSC_EXC_RESET;
               seq_next = PSC_SEQ_RESET_LEN;
            end
            PSC_RUN:
            begin
               rel_next = i_bus_release_req;
               if (i_instr_end)
                  noirq_next = 1'b0;
               if (!rel_reg)
               begin
                  if (irq_ok)
                  begin
                     // Interrupt beats a trap in the same cycle
                     state_next = PSC_EXC;
                     kind_next = PSC_EXC_IRQ;
                     seq_next = PSC_SEQ_PUSH_LEN;
                     acc_next = 1'b1;
                  end
                  else if (i_trap_instruction)
                  begin
                     state_next = PSC_EXC;
                     kind_next = PSC_EXC_TRAP;
                     seq_next = PSC_SEQ_PUSH_LEN;
                  end
                  else if (i_sleep_instr)
                     state_next = i_standby_select_bit ? PSC_SWSTBY : PSC_SLEEP;
               end
            end
            PSC_EXC:
            begin
               seq_next = seq_reg - 3'h1;
               // Push first, then flag update, then vector fetch
               if (kind_reg != PSC_EXC_RESET && seq_reg == PSC_SEQ_PUSH_LEN)
                  push_next = 1'b1;
               if (kind_reg != PSC_EXC_RESET && seq_reg == PSC_SEQ_PUSH_LEN - 3'h1)
               begin
                  mask_next = 1'b1;
                  if (!i_user_flag_enable)
                     umask_next = 1'b1;
               end
               if (seq_reg == 3'h2)
                  vec_next = 1'b1;
               if (seq_last)
               begin
                  if (irq_ok)
                  begin
                     kind_next = PSC_EXC_IRQ;
                     seq_next = PSC_SEQ_PUSH_LEN;
                     acc_next = 1'b1;
                  end
                  else
                     state_next = PSC_RUN;
               end
            end
            PSC_SLEEP:
               if (i_wake)
                  state_next = PSC_RUN;
            PSC_SWSTBY:
               // Software standby keeps registers; modules held in reset
               if (i_wake)
                  state_next = PSC_RUN;
            PSC_HWSTBY:
               state_next = PSC_RESET;
            default:
               state_next = PSC_RESET;
         endcase
      end
   end

   // Decodes registered so no output pin shows decode glitches
   always_comb
   begin
      exc_next = (state_next == PSC_EXC);
      halt_next = (state_next == PSC_SWSTBY) || (state_next == PSC_HWSTBY);
      cpuh_next = halt_next || (state_next == PSC_SLEEP) || (state_next == PSC_RESET);
      wsp_next = (mode_next != PSC_MODE_2);
      b8_next = (mode_next == PSC_MODE_1);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state_reg <= PSC_RESET;
         kind_reg <= PSC_EXC_RESET;
         seq_reg <= 3'h0;
         mask_reg <= 1'b1;
         umask_reg <= 1'b0;
         noirq_reg <= 1'b1;
         push_reg <= 1'b0;
         vec_reg <= 1'b0;
         acc_reg <= 1'b0;
         rel_reg <= 1'b0;
         mode_reg <= PSC_MODE_BAD;
         exc_reg <= 1'b0;
         halt_reg <= 1'b0;
         cpuh_reg <= 1'b1;
         wsp_reg <= 1'b1;
         b8_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         kind_reg <= kind_next;
         seq_reg <= seq_next;
         mask_reg <= mask_next;
         umask_reg <= umask_next;
         noirq_reg <= noirq_next;
         push_reg <= push_next;
         vec_reg <= vec_next;
         acc_reg <= acc_next;
         rel_reg <= rel_next;
         mode_reg <= mode_next;
         exc_reg <= exc_next;
         halt_reg <= halt_next;
         cpuh_reg <= cpuh_next;
         wsp_reg <= wsp_next;
         b8_reg <= b8_next;
      end
   end

   assign o_state = state_reg;
   assign o_bus_released = rel_reg;
   assign o_exc_active = exc_reg;
   assign o_exc_kind = kind_reg;
   assign o_push_ctx = push_reg;
   assign o_vector_fetch = vec_reg;
   assign o_irq_accept = acc_reg;
   assign o_mask_flag = mask_reg;
   assign o_second_mask_flag = umask_reg;
   assign o_clock_halt = halt_reg;
   assign o_modules_reset = halt_reg;
   assign o_cpu_halt = cpuh_reg;
   assign o_mode = mode_reg;
   assign o_wide_space = wsp_reg;
   assign o_initial_bus_8bit = b8_reg;

   psc_bus_timer #(
      .AREAS(AREAS)
   ) u_timer (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_start(i_bus_start),
      .i_onchip_mem(i_bus_onchip_mem),
      .i_periph(i_bus_periph),
      .i_area(i_bus_area),
      .i_area_three(i_area_three),
      .i_area_wide(i_area_wide),
      .i_periph_wide(i_bus_periph_wide),
      .o_busy(o_bus_busy),
      .o_done(o_bus_done),
      .o_wide(o_bus_wide)
   );

   psc_ram_gate u_ram (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_mode(mode_reg),
      .i_ram_enable(i_onchip_ram_enable),
      .i_ram_range(i_ram_range),
      .i_write(i_ram_write),
      .i_ram_rdata(i_ram_rdata),
      .o_to_external(o_ram_to_external),
      .o_ram_write(o_ram_write),
      .o_rdata(o_ram_rdata)
   );

   reset_enter_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !i_reset_input_low |=> state_reg == PSC_RESET && mask_reg)
      else $error("reset input low did not reset");
   wdog_reset_a: assert property (@(posedge i_clk) disable iff (i_reset)
      i_watchdog_overflow |=> state_reg == PSC_RESET)
      else $error("watchdog overflow did not reset");
   reset_seq_a: assert property (@(posedge i_clk) disable iff (i_reset)
      state_reg == PSC_RESET && !in_reset && i_hw_standby_pin_low
      |=> state_reg == PSC_EXC && kind_reg == PSC_EXC_RESET)
      else $error("reset sequence did not start");
   no_irq_reset_a: assert property (@(posedge i_clk) disable iff (i_reset)
      state_reg == PSC_EXC && kind_reg == PSC_EXC_RESET |-> !acc_next)
      else $error("interrupt taken in reset sequence");
   irq_prio_a: assert property (@(posedge i_clk) disable iff (i_reset)
      state_reg == PSC_RUN && irq_ok && i_trap_instruction && !in_reset && i_hw_standby_pin_low && !rel_reg
      |=> kind_reg == PSC_EXC_IRQ)
      else $error("trap beat interrupt");
   flag_op_a: assert property (@(posedge i_clk) disable iff (i_reset)
      state_reg == PSC_RUN && i_instr_flags_op && !i_trap_instruction |=> !acc_reg)
      else $error("interrupt after flag op");
   mask_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
      o_push_ctx && !in_reset && i_hw_standby_pin_low && !i_user_flag_enable
      |=> mask_reg && umask_reg)
      else $error("masks not set after push");
   sleep_a: assert property (@(posedge i_clk) disable iff (i_reset)
      state_reg == PSC_RUN && i_sleep_instr && !i_trap_instruction && !irq_ok && !rel_reg
      && !in_reset && i_hw_standby_pin_low
      |=> state_reg == (i_standby_select_bit ? PSC_SWSTBY : PSC_SLEEP))
      else $error("sleep entry wrong");
   hw_hw_standby_pin_low_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !in_reset && !i_hw_standby_pin_low |=> state_reg == PSC_HWSTBY && o_clock_halt && o_modules_reset)
      else $error("hardware standby not entered");
endmodule

/* File: bench/psc_partner.sv */
`timescale 1ns/1ps
module psc_partner
   import psc_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Bench requests
   input wire logic [1:0] i_mode_sel,
   input wire logic i_raise,
   input wire logic i_nmi,
   // From the block
   input wire logic i_irq_accept,
   // Towards the block
   output logic o_mode_pin_high,
   output logic o_mode_pin_low,
   output logic o_irq_pending,
   output logic o_irq_nmi
);
   logic pend_reg = 1'b0;
   logic nmi_reg = 1'b0;
   // Bench moves the code only while reset is held
   assign o_mode_pin_high = i_mode_sel[1];
   assign o_mode_pin_low = i_mode_sel[0];
   assign o_irq_pending = pend_reg;
   assign o_irq_nmi = nmi_reg;
   // Request stays up until taken, as a real controller keeps it
   always @(posedge i_clk)
   begin
      if (i_reset || i_irq_accept)
         pend_reg <= 1'b0;
      else if (i_raise)
         pend_reg <= 1'b1;
      nmi_reg <= i_nmi;
   end
endmodule

/* File: bench/psc_top_tb.sv */
`timescale 1ns/1ps
module psc_top_tb
   import psc_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_reset_input_low = 1'b1, i_watchdog_overflow = 1'b0, i_hw_standby_pin_low = 1'b1;
   logic i_standby_select_bit = 1'b0, i_user_flag_enable = 1'b1, i_onchip_ram_enable = 1'b1;
   logic i_instr_end = 1'b0, i_instr_flags_op = 1'b0, i_trap_instruction = 1'b0, i_sleep_instr = 1'b0;
   logic i_wake = 1'b0, i_bus_start = 1'b0, i_bus_onchip_mem = 1'b0, i_bus_periph = 1'b0;
   logic i_bus_periph_wide = 1'b0, i_bus_release_req = 1'b0, i_ram_range = 1'b0, i_ram_write = 1'b0;
   logic [2:0] i_bus_area = 3'h0;
   logic [7:0] i_area_three = 8'hA5, i_area_wide = 8'h33, i_ram_rdata = 8'h5A;
   logic i_mode_pin_high, i_mode_pin_low, i_irq_pending, i_irq_nmi;
   logic [1:0] msel = 2'h1;
   logic raise = 1'b0, nmi = 1'b0;
   psc_state_t o_state;
   psc_exc_t o_exc_kind;
   logic o_bus_released, o_exc_active, o_push_ctx, o_vector_fetch, o_irq_accept, o_mask_flag;
   logic o_second_mask_flag, o_clock_halt, o_modules_reset, o_cpu_halt, o_wide_space, o_initial_bus_8bit;
   logic o_bus_busy, o_bus_done, o_bus_wide, o_ram_to_external, o_ram_write;
   logic [1:0] o_mode;
   logic [7:0] o_ram_rdata;
   int n_fail = 0, tests_run = 0, n_acc = 0, cyc = 0;

   psc_top psc_top_i (.i_clk, .i_reset, .i_reset_input_low, .i_watchdog_overflow, .i_hw_standby_pin_low,
      .i_mode_pin_high, .i_mode_pin_low, .i_standby_select_bit, .i_user_flag_enable, .i_onchip_ram_enable,
      .i_instr_end, .i_instr_flags_op, .i_trap_instruction, .i_sleep_instr, .i_wake, .i_irq_pending,
      .i_irq_nmi, .i_bus_start, .i_bus_onchip_mem, .i_bus_periph, .i_bus_periph_wide, .i_bus_area,
      .i_area_three, .i_area_wide, .i_bus_release_req, .i_ram_range, .i_ram_write, .i_ram_rdata,
      .o_state, .o_bus_released, .o_exc_active, .o_exc_kind, .o_push_ctx, .o_vector_fetch, .o_irq_accept,
      .o_mask_flag, .o_second_mask_flag, .o_clock_halt, .o_modules_reset, .o_cpu_halt, .o_mode,
      .o_wide_space, .o_initial_bus_8bit, .o_bus_busy, .o_bus_done, .o_bus_wide, .o_ram_to_external,
      .o_ram_write, .o_ram_rdata);

   psc_partner psc_partner_i (.i_clk, .i_reset, .i_mode_sel(msel), .i_raise(raise), .i_nmi(nmi),
      .i_irq_accept(o_irq_accept), .o_mode_pin_high(i_mode_pin_high), .o_mode_pin_low(i_mode_pin_low),
      .o_irq_pending(i_irq_pending), .o_irq_nmi(i_irq_nmi));

   always #5 i_clk = ~i_clk;

   // Accept count and hang guard
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (o_irq_accept === 1'b1)
         n_acc <= n_acc + 1;
      if (cyc == 3000)
      begin
         n_fail = n_fail + 1;
         test_done;
      end
   end

   task test_done;
      if (n_fail == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
         n_fail = n_fail + 1;
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // Bounded wait; the short delay keeps the look off the edge
   task wst(input psc_state_t s);
      #1;
      for (int k = 0; k < 12 && o_state !== s; k++)
         tick(1);
   endtask

   task end_instr(input logic f);
      @(posedge i_clk);
      i_instr_end <= 1'b1;
      i_instr_flags_op <= f;
      @(posedge i_clk);
      i_instr_end <= 1'b0;
      i_instr_flags_op <= 1'b0;
   endtask

   task raise_nmi;
      @(posedge i_clk);
      raise <= 1'b1;
      nmi <= 1'b1;
      @(posedge i_clk);
      raise <= 1'b0;
   endtask

   task seq(input psc_exc_t k, input logic c2);
      int n;
      int pc;
      int vc;
      n = 0;
      pc = 0;
      vc = 0;
      wst(PSC_EXC);
      chk(o_exc_kind, k);
      chk(o_exc_active, 1'b1);
      while (o_state === PSC_EXC && n < 8)
      begin
         n++;
         if (o_push_ctx === 1'b1)
            pc = n;
         if (o_vector_fetch === 1'b1)
            vc = n;
         tick(1);
      end
      chk(8'(n), (k == PSC_EXC_RESET) ? 8'h02 : 8'h04);
      chk(vc != 0, 1'b1);
      chk(pc != 0 && pc < vc, k != PSC_EXC_RESET);
      chk(o_state, PSC_RUN);
      chk(o_mask_flag, 1'b1);
      if (c2)
         chk(o_second_mask_flag, 1'b1);
   endtask

   // Mode code moves only while the pin holds reset
   task reset_pin(input logic [1:0] m);
      @(posedge i_clk);
      i_reset_input_low <= 1'b0;
      msel <= m;
      wst(PSC_RESET);
      tick(2);
      chk(o_state, PSC_RESET);
      chk(o_mask_flag, 1'b1);
      chk(o_cpu_halt, 1'b1);
      chk(o_mode, m);
      chk(o_wide_space, m != PSC_MODE_2);
      chk(o_initial_bus_8bit, m == PSC_MODE_1);
      @(posedge i_clk);
      i_reset_input_low <= 1'b1;
      seq(PSC_EXC_RESET, 1'b0);
   endtask

   task t_reset;
      int a;
      raise_nmi;
      reset_pin(PSC_MODE_3);
      a = n_acc;
      tick(6);
      chk(8'(n_acc - a), 8'h00);
      end_instr(1'b1);
      tick(6);
      chk(8'(n_acc - a), 8'h00);
      end_instr(1'b0);
      seq(PSC_EXC_IRQ, 1'b0);
      chk(8'(n_acc - a), 8'h01);
   endtask

   task t_trap;
      @(posedge i_clk);
      i_user_flag_enable <= 1'b0;
      i_trap_instruction <= 1'b1;
      @(posedge i_clk);
      i_trap_instruction <= 1'b0;
      seq(PSC_EXC_TRAP, 1'b1);
      raise_nmi;
      @(posedge i_clk);
      i_trap_instruction <= 1'b1;
      i_instr_end <= 1'b1;
      @(posedge i_clk);
      i_trap_instruction <= 1'b0;
      i_instr_end <= 1'b0;
      seq(PSC_EXC_IRQ, 1'b1);
   endtask

   task t_wdog;
      int a;
      raise_nmi;
      @(posedge i_clk);
      i_watchdog_overflow <= 1'b1;
      i_instr_end <= 1'b1;
      @(posedge i_clk);
      i_instr_end <= 1'b0;
      wst(PSC_RESET);
      chk(o_state, PSC_RESET);
      chk(o_mask_flag, 1'b1);
      @(posedge i_clk);
      i_watchdog_overflow <= 1'b0;
      reset_pin(PSC_MODE_3);
      a = n_acc;
      end_instr(1'b0);
      tick(2);
      chk(8'(n_acc - a), 8'h00);
      end_instr(1'b0);
      seq(PSC_EXC_IRQ, 1'b0);
   endtask

   task slp(input logic s, input psc_state_t e);
      @(posedge i_clk);
      i_standby_select_bit <= s;
      i_sleep_instr <= 1'b1;
      @(posedge i_clk);
      i_sleep_instr <= 1'b0;
      wst(e);
      chk(o_state, e);
      chk(o_cpu_halt, 1'b1);
      chk(o_clock_halt, s);
      chk(o_modules_reset, s);
      @(posedge i_clk);
      i_wake <= 1'b1;
      @(posedge i_clk);
      i_wake <= 1'b0;
      wst(PSC_RUN);
      chk(o_state, PSC_RUN);
   endtask

   task t_power;
      slp(1'b0, PSC_SLEEP);
      slp(1'b1, PSC_SWSTBY);
      @(posedge i_clk);
      i_hw_standby_pin_low <= 1'b0;
      wst(PSC_HWSTBY);
      chk(o_state, PSC_HWSTBY);
      chk(o_clock_halt, 1'b1);
      chk(o_modules_reset, 1'b1);
      @(posedge i_clk);
      i_hw_standby_pin_low <= 1'b1;
      reset_pin(PSC_MODE_1);
   endtask

   task bus(input logic m, input logic p, input logic pw, input logic [2:0] a, input int len, input logic w);
      int n;
      logic ww;
      n = 0;
      ww = ~w;
      @(posedge i_clk);
      i_bus_start <= 1'b1;
      i_bus_onchip_mem <= m;
      i_bus_periph <= p;
      i_bus_periph_wide <= pw;
      i_bus_area <= a;
      @(posedge i_clk);
      i_bus_start <= 1'b0;
      #1;
      for (int k = 0; k < 8 && o_bus_done !== 1'b1; k++)
      begin
         if (o_bus_busy === 1'b1)
            n++;
         if (n == 1)
            ww = o_bus_wide;
         tick(1);
      end
      chk(8'(n), 8'(len));
      chk(ww, w);
   endtask

   task t_bus;
      bus(1'b1, 1'b0, 1'b0, 3'h0, 2, 1'b1);
      bus(1'b0, 1'b1, 1'b0, 3'h0, 3, 1'b0);
      bus(1'b0, 1'b1, 1'b1, 3'h0, 3, 1'b1);
      for (int a = 0; a < 8; a++)
         bus(1'b0, 1'b0, 1'b0, 3'(a), i_area_three[a] ? 3 : 2, i_area_wide[a]);
   endtask

   task t_rel;
      int a;
      end_instr(1'b0);
      @(posedge i_clk);
      i_bus_release_req <= 1'b1;
      raise_nmi;
      tick(2);
      chk(o_bus_released, 1'b1);
      a = n_acc;
      end_instr(1'b0);
      tick(6);
      chk(8'(n_acc - a), 8'h00);
      @(posedge i_clk);
      i_bus_release_req <= 1'b0;
      tick(2);
      chk(o_bus_released, 1'b0);
      end_instr(1'b0);
      seq(PSC_EXC_IRQ, 1'b0);
   endtask

   task ram(input logic en, input logic ext, input logic wr, input logic [7:0] rd);
      @(posedge i_clk);
      i_onchip_ram_enable <= en;
      i_ram_range <= 1'b1;
      i_ram_write <= 1'b1;
      tick(1);
      chk(o_ram_to_external, ext);
      chk(o_ram_write, wr);
      @(posedge i_clk);
      i_ram_write <= 1'b0;
      tick(1);
      if (!ext)
         chk(o_ram_rdata, rd);
   endtask

   task t_mode(input logic [1:0] m);
      reset_pin(m);
      ram(1'b0, m == PSC_MODE_1, 1'b0, PSC_RAM_OFF_DATA);
      ram(1'b1, 1'b0, 1'b1, 8'h5A);
   endtask

   initial
   begin
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      t_reset;
      t_trap;
      t_wdog;
      t_power;
      t_bus;
      t_rel;
      for (int m = 1; m < 4; m++)
         t_mode(2'(m));
      test_done;
   end
endmodule
